// >>> hdl/rio_map.svh
// Offsets, field positions, reset values and timing of the relay I/O block
`ifndef RIO_MAP_SVH
`define RIO_MAP_SVH
`define RIO_IDX_BIN_FUNC 4'h0
`define RIO_IDX_ROUTE0 4'h1
`define RIO_IDX_ROUTE5 4'h6
`define RIO_IDX_HOLD 4'h7
`define RIO_IDX_RETAIN 4'h8
`define RIO_IDX_LATCH 4'h9
`define RIO_IDX_MODE 4'hA
`define RIO_BF_CLR_IND 0
`define RIO_BF_CLR_UNL 1
`define RIO_BF_CLR_MEM 2
`define RIO_BF_GROUP 3
`define RIO_BF_BLK0 4
`define RIO_BF_ANGLE 7
`define RIO_MODE_GROUP 0
`define RIO_MODE_ANGLE 1
`define RIO_RST_BIN_FUNC 8'h00
`define RIO_RST_START_ROUTE 4'hC
`define RIO_RST_TRIP_ROUTE 4'h3
`define RIO_RST_HOLD 10'h03C
`define RIO_HOLD_MAX 10'h3E6
`define RIO_HOLD_FOREVER 10'h3E7
`define RIO_RST_RETAIN 8'h1F
`define RIO_RETAIN_MASK 8'h1F
`define RIO_CLK_NS 5
`define RIO_MS_NS 1000000
`define RIO_MIN_MS 60000
`endif

// >>> hdl/rio_pkg.sv
// Types shared by the relay I/O block
`default_nettype none
package rio_pkg;
  typedef enum logic [2:0] {
    RIO_EMPTY = 3'h1,
    RIO_HOLD = 3'h2,
    RIO_OPEN = 3'h4
  } rio_ind_e;
  typedef logic [3:0] rio_route_t;
endpackage
`default_nettype wire

// >>> hdl/rio_sync.sv
// Two-stage synchroniser for the binary input pin
`default_nettype none
module rio_sync (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic async_i,
  output logic sync_o
);
  logic meta_ff;
  logic nxt_meta;
  logic nxt_sync;
  always_comb begin
    nxt_meta = async_i;
    nxt_sync = meta_ff;
  end
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      meta_ff <= 1'b0;
      sync_o <= 1'b0;
    end else begin
      meta_ff <= nxt_meta;
      sync_o <= nxt_sync;
    end
  end
endmodule
`default_nettype wire

// >>> hdl/rio_div.sv
// Enable divider: one-cycle tick every DIV enabled cycles
`default_nettype none
module rio_div #(
  parameter int unsigned DIV = 200000
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic en_i,
  output logic tick_o
);
  localparam int W = $clog2(DIV + 1);
  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;
  logic nxt_tick;
  if (DIV < 1) begin : g_bad_div
    $error("DIV must be at least 1");
  end
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_tick = 1'b0;
    if (en_i) begin
      if (cnt_ff == W'(DIV - 1)) begin
        nxt_cnt = '0;
        nxt_tick = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + W'(1);
      end
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      cnt_ff <= '0;
      tick_o <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      tick_o <= nxt_tick;
    end
  end
endmodule
`default_nettype wire

// >>> hdl/rio_top.sv
// Relay binary input functions, contact routing and trip indication hold
//
// What this block does
// - Function switch 1 set: the binary input clears indications.
// - Switch 2 set: the input clears indications and unlatches contacts.
// - Switch 3 set: the input also clears memorized values; default off.
// - Switch 4 set: energized input selects group 2, else group 1.
// - Switches 5 to 7 block their stage's trip while the input is high.
// - Switch 8 set: input low gives -90 deg/sine, high gives 0 deg/cosine.
// - Six routing groups route stage starts and trips to four contacts.
// - Start routing groups reset to 12, trip routing groups to 3.
// - A group's checksum is the sum of weights of its set switches.
// - The first trip indication stays until the hold time has run out.
// - Hold time 0 to 998 minutes, default 60; 999 holds until cleared.
// - The hold time has no effect on stage start, timing or trip.
// - Retention switch 1 keeps alarm messages and LEDs; default 1.
// - Retention switches 2 to 5 keep data; 6 to 8 unused; default 31.
`include "rio_map.svh"
`default_nettype none
module rio_top #(
  parameter int unsigned MS_CYC = `RIO_MS_NS / `RIO_CLK_NS,
  parameter int unsigned MIN_MS = `RIO_MIN_MS
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic bin_in_i,
  input wire logic [2:0] stage_start_i,
  input wire logic [2:0] stage_trip_i,
  input wire logic manual_clear_i,
  input wire logic cfg_we_i,
  input wire logic [3:0] cfg_addr_i,
  input wire logic [9:0] cfg_data_i,
  output logic [9:0] cfg_rdata_o,
  output logic power_output_one_o,
  output logic power_output_two_o,
  output logic signal_output_one_o,
  output logic signal_output_two_o,
  output logic [2:0] stage_trip_o,
  output logic setting_group_o,
  output logic basic_angle_cos_o,
  output logic clear_indication_o,
  output logic clear_memorized_o,
  output logic [2:0] shown_trip_o,
  output logic [4:0] retention_o
);
  if (MS_CYC < 1 || MIN_MS < 1) begin : g_bad_div
    $error("Divider counts must be nonzero");
  end

  // Weight of switch n (1-based) in a group
  function automatic logic [7:0] sw_weight(input int unsigned n);
    sw_weight = 8'(1 << (n - 1));
  endfunction

  // Sum of weights of the set switches of a group
  function automatic logic [9:0] checksum(input logic [7:0] g);
    logic [9:0] s;
    s = '0;
    for (int unsigned n = 1; n <= 8; n++) begin
      if (g[n-1]) s = s + {2'h0, sw_weight(n)};
    end
    checksum = s;
  endfunction

  logic bi_s;
  logic ms_tick;
  logic min_tick;

  rio_sync u_sync (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i(bin_in_i),
    .sync_o(bi_s)
  );
  rio_div #(.DIV(MS_CYC)) u_ms (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .en_i(1'b1),
    .tick_o(ms_tick)
  );
  rio_div #(.DIV(MIN_MS)) u_min (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .en_i(ms_tick),
    .tick_o(min_tick)
  );

  // Settings
  logic [7:0] bin_func_ff;
  rio_pkg::rio_route_t route_ff [6];
  logic [9:0] hold_ff;
  logic [7:0] retain_ff;
  logic [3:0] latch_sel_ff;
  logic [1:0] mode_ff;
  logic [7:0] nxt_bin_func;
  rio_pkg::rio_route_t nxt_route [6];
  logic [9:0] nxt_hold;
  logic [7:0] nxt_retain;
  logic [3:0] nxt_latch_sel;
  logic [1:0] nxt_mode;

  always_comb begin
    nxt_bin_func = bin_func_ff;
    nxt_route = route_ff;
    nxt_hold = hold_ff;
    nxt_retain = retain_ff;
    nxt_latch_sel = latch_sel_ff;
    nxt_mode = mode_ff;
    if (cfg_we_i) begin
      case (cfg_addr_i)
        `RIO_IDX_BIN_FUNC: nxt_bin_func = cfg_data_i[7:0];
        `RIO_IDX_HOLD: begin
          if (cfg_data_i <= `RIO_HOLD_FOREVER) nxt_hold = cfg_data_i;
        end
        `RIO_IDX_RETAIN: nxt_retain = cfg_data_i[7:0] & `RIO_RETAIN_MASK;
        `RIO_IDX_LATCH: nxt_latch_sel = cfg_data_i[3:0];
        `RIO_IDX_MODE: nxt_mode = cfg_data_i[1:0];
        default: begin
          for (int k = 0; k < 6; k++) begin
            if (cfg_addr_i == `RIO_IDX_ROUTE0 + 4'(k)) begin
              nxt_route[k] = cfg_data_i[3:0];
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      bin_func_ff <= `RIO_RST_BIN_FUNC;
      for (int k = 0; k < 6; k++) begin
        route_ff[k] <= k[0] ? `RIO_RST_TRIP_ROUTE : `RIO_RST_START_ROUTE;
      end
      hold_ff <= `RIO_RST_HOLD;
      retain_ff <= `RIO_RST_RETAIN;
      latch_sel_ff <= 4'h0;
      mode_ff <= 2'h0;
    end else begin
      bin_func_ff <= nxt_bin_func;
      route_ff <= nxt_route;
      hold_ff <= nxt_hold;
      retain_ff <= nxt_retain;
      latch_sel_ff <= nxt_latch_sel;
      mode_ff <= nxt_mode;
    end
  end

  // Binary input actions
  logic bi_clr_ind;
  logic bi_unlatch;
  logic bi_clr_mem;
  logic [2:0] blk;
  logic [2:0] trip_eff;
  logic [3:0] raw_contact;
  always_comb begin
    bi_clr_ind = bi_s & (bin_func_ff[`RIO_BF_CLR_IND]
      | bin_func_ff[`RIO_BF_CLR_UNL] | bin_func_ff[`RIO_BF_CLR_MEM]);
    bi_unlatch = bi_s & (bin_func_ff[`RIO_BF_CLR_UNL]
      | bin_func_ff[`RIO_BF_CLR_MEM]);
    bi_clr_mem = bi_s & bin_func_ff[`RIO_BF_CLR_MEM];
    blk = {3{bi_s}} & bin_func_ff[`RIO_BF_BLK0 +: 3];
    trip_eff = stage_trip_i & ~blk;
    raw_contact = 4'h0;
    for (int k = 0; k < 3; k++) begin
      if (stage_start_i[k]) raw_contact = raw_contact | route_ff[2*k];
      if (trip_eff[k]) raw_contact = raw_contact | route_ff[2*k+1];
    end
  end

  // Trip indication hold
  rio_pkg::rio_ind_e ind_ff;
  rio_pkg::rio_ind_e nxt_ind;
  logic [2:0] shown_ff;
  logic [2:0] nxt_shown;
  logic [9:0] min_cnt_ff;
  logic [9:0] nxt_min_cnt;
  logic [2:0] trip_prev_ff;
  logic [2:0] trip_rise;
  logic [2:0] first_rise;
  logic ind_clear;

  always_comb begin
    trip_rise = trip_eff & ~trip_prev_ff;
    first_rise = trip_rise & (~trip_rise + 3'h1);
    ind_clear = manual_clear_i | bi_clr_ind;
    nxt_ind = ind_ff;
    nxt_shown = shown_ff;
    nxt_min_cnt = min_cnt_ff;
    if (ind_clear) begin
      nxt_ind = rio_pkg::RIO_EMPTY;
      nxt_shown = 3'h0;
    end
    case (ind_ff)
      rio_pkg::RIO_HOLD: begin
        if (!ind_clear && hold_ff != `RIO_HOLD_FOREVER) begin
          if (min_cnt_ff >= hold_ff) nxt_ind = rio_pkg::RIO_OPEN;
          else if (min_tick) nxt_min_cnt = min_cnt_ff + 10'h1;
        end
      end
      rio_pkg::RIO_EMPTY, rio_pkg::RIO_OPEN: ;
      default: nxt_ind = rio_pkg::RIO_EMPTY;
    endcase
    // new trip shown when allowed; set beats clear
    if (first_rise != 3'h0 && (ind_clear || ind_ff != rio_pkg::RIO_HOLD)) begin
      nxt_shown = first_rise;
      nxt_min_cnt = 10'h0;
      nxt_ind = (hold_ff == 10'h0) ? rio_pkg::RIO_OPEN : rio_pkg::RIO_HOLD;
    end
  end

  // Contact latching and registered outputs
  logic [3:0] latch_ff;
  logic [3:0] nxt_latch;
  logic [3:0] nxt_contact;
  always_comb begin
    nxt_latch = bi_unlatch ? 4'h0 : latch_ff;
    nxt_latch = nxt_latch | (raw_contact & latch_sel_ff);
    nxt_contact = raw_contact | (bi_unlatch ? 4'h0 : latch_ff);
  end

  logic nxt_group;
  logic nxt_angle;
  logic [9:0] nxt_rdata;
  always_comb begin
    nxt_group = bin_func_ff[`RIO_BF_GROUP] ? bi_s : mode_ff[`RIO_MODE_GROUP];
    // group follows input only while switch 4 set
    nxt_angle = bin_func_ff[`RIO_BF_ANGLE] ? bi_s : mode_ff[`RIO_MODE_ANGLE];
    case (cfg_addr_i)
      `RIO_IDX_BIN_FUNC: nxt_rdata = checksum(bin_func_ff);
      `RIO_IDX_HOLD: nxt_rdata = hold_ff;
      `RIO_IDX_RETAIN: nxt_rdata = checksum(retain_ff);
      `RIO_IDX_LATCH: nxt_rdata = {6'h0, latch_sel_ff};
      `RIO_IDX_MODE: nxt_rdata = {8'h0, mode_ff};
      default: begin
        nxt_rdata = 10'h0;
        for (int k = 0; k < 6; k++) begin
          if (cfg_addr_i == `RIO_IDX_ROUTE0 + 4'(k)) begin
            nxt_rdata = checksum({4'h0, route_ff[k]});
          end
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      ind_ff <= rio_pkg::RIO_EMPTY;
      shown_ff <= 3'h0;
      min_cnt_ff <= 10'h0;
      trip_prev_ff <= 3'h0;
      latch_ff <= 4'h0;
      {signal_output_two_o, signal_output_one_o} <= 2'h0;
      {power_output_two_o, power_output_one_o} <= 2'h0;
      stage_trip_o <= 3'h0;
      setting_group_o <= 1'b0;
      basic_angle_cos_o <= 1'b0;
      clear_indication_o <= 1'b0;
      clear_memorized_o <= 1'b0;
      shown_trip_o <= 3'h0;
      retention_o <= 5'h1F;
      cfg_rdata_o <= 10'h0;
    end else begin
      ind_ff <= nxt_ind;
      shown_ff <= nxt_shown;
      min_cnt_ff <= nxt_min_cnt;
      trip_prev_ff <= trip_eff;
      latch_ff <= nxt_latch;
      {signal_output_two_o, signal_output_one_o} <= nxt_contact[3:2];
      {power_output_two_o, power_output_one_o} <= nxt_contact[1:0];
      // trips never gated by indication state
      stage_trip_o <= trip_eff;
      setting_group_o <= nxt_group;
      basic_angle_cos_o <= nxt_angle;
      clear_indication_o <= bi_clr_ind;
      clear_memorized_o <= bi_clr_mem;
      shown_trip_o <= nxt_shown;
      retention_o <= retain_ff[4:0];
      cfg_rdata_o <= nxt_rdata;
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  AST_CLR_IND: assert property (bi_s && bin_func_ff[0] |=>
    clear_indication_o) else $error("Indication clear missing");
  AST_NO_CLR: assert property (!bi_s |=> !clear_indication_o)
    else $error("Indication cleared without input");
  AST_UNLATCH: assert property (bi_unlatch && raw_contact == 4'h0
    |=> !power_output_one_o && latch_ff == 4'h0)
    else $error("Contact not unlatched");
  AST_MEM: assert property (clear_memorized_o
    |-> $past(bi_s) && $past(bin_func_ff[2]))
    else $error("Memorized clear without cause");
  AST_GROUP: assert property (bin_func_ff[3] && $stable(bin_func_ff)
    |=> setting_group_o == $past(bi_s)) else $error("Group mismatch");
  AST_BLOCK: assert property (bi_s && bin_func_ff[4]
    |=> !stage_trip_o[0]) else $error("Blocked trip passed");
  AST_ANGLE: assert property (bin_func_ff[7]
    |=> basic_angle_cos_o == $past(bi_s)) else $error("Angle mismatch");
  AST_ROUTE: assert property (stage_start_i[0] && route_ff[0][2]
    |=> signal_output_one_o) else $error("Start not routed");
  AST_FOREVER: assert property (ind_ff == rio_pkg::RIO_HOLD
    && hold_ff == `RIO_HOLD_FOREVER && !ind_clear
    |=> ind_ff != rio_pkg::RIO_OPEN)
    else $error("Forever hold expired");
  AST_KEEP: assert property (ind_ff == rio_pkg::RIO_HOLD && !ind_clear
    |=> shown_trip_o == $past(shown_trip_o)) else $error("Indication replaced");

  COV_BLOCK: cover property (bi_s && bin_func_ff[5] && stage_trip_i[1]);
  COV_OPEN: cover property (ind_ff == rio_pkg::RIO_HOLD
    ##1 ind_ff == rio_pkg::RIO_OPEN);
  COV_GROUP2: cover property (setting_group_o && bin_func_ff[3]);
endmodule
`default_nettype wire

// >>> testbench/rio_gear.sv
// Switchgear wiring model: binary input pin and stage signal lines
`default_nettype none
module rio_gear (
  input wire logic bin_cmd_i,
  input wire logic [2:0] start_cmd_i,
  input wire logic [2:0] trip_cmd_i,
  output logic bin_in_o,
  output logic [2:0] stage_start_o,
  output logic [2:0] stage_trip_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // Energized contact drives the pin high
  assign bin_in_o = bin_cmd_i;
  assign stage_start_o = start_cmd_i;
  assign stage_trip_o = trip_cmd_i;
endmodule
`default_nettype wire

// >>> testbench/rio_top_bench.sv
// Self-checking bench of the relay I/O block
`default_nettype none
module rio_top_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic bin_cmd = 1'b0;
  logic manual_clear = 1'b0;
  logic cfg_we = 1'b0;
  logic [2:0] start_cmd = 3'h0;
  logic [2:0] trip_cmd = 3'h0;
  logic [3:0] cfg_addr = 4'h0;
  logic [9:0] cfg_data = 10'h000;
  logic [9:0] rdata;
  logic po1, po2, so1, so2, grp, ang, ci, cm, bin_pin;
  logic [2:0] strip, shown, st_pin, tr_pin;
  logic [4:0] ret;
  logic [3:0] cont;
  logic [3:0] rt [1:6];
  logic [31:0] seed = 32'h00007D69;
  int mismatches = 0;
  int num_checks = 0;
  int g;
  int ks [6] = '{0, 1, 2, 3, 7, 8};

  assign cont = {so2, so1, po2, po1};
  always #2.5 sys_clk_i = ~sys_clk_i;

  rio_gear gear (.bin_cmd_i(bin_cmd), .start_cmd_i(start_cmd),
    .trip_cmd_i(trip_cmd), .bin_in_o(bin_pin), .stage_start_o(st_pin),
    .stage_trip_o(tr_pin));

  rio_top #(.MS_CYC(4), .MIN_MS(5)) uut (.sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i), .bin_in_i(bin_pin), .stage_start_i(st_pin),
    .stage_trip_i(tr_pin), .manual_clear_i(manual_clear),
    .cfg_we_i(cfg_we), .cfg_addr_i(cfg_addr), .cfg_data_i(cfg_data),
    .cfg_rdata_o(rdata), .power_output_one_o(po1),
    .power_output_two_o(po2), .signal_output_one_o(so1),
    .signal_output_two_o(so2), .stage_trip_o(strip),
    .setting_group_o(grp), .basic_angle_cos_o(ang),
    .clear_indication_o(ci), .clear_memorized_o(cm),
    .shown_trip_o(shown), .retention_o(ret));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  function automatic logic [3:0] exp_cont(input logic [2:0] s, t);
    logic [3:0] c;
    c = 4'h0;
    for (int k = 0; k < 3; k++) begin
      if (s[k]) c = c | rt[2 * k + 1];
      if (t[k]) c = c | rt[2 * k + 2];
    end
    return c;
  endfunction

  task automatic tick();
    @(posedge sys_clk_i);
    #1;
  endtask

  task automatic chk(input logic [15:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [9:0] d);
    cfg_addr = a;
    cfg_data = d;
    cfg_we = 1'b1;
    tick();
    cfg_we = 1'b0;
    tick();
  endtask

  task automatic rdc(input logic [3:0] a, input logic [9:0] e);
    cfg_addr = a;
    tick();
    chk(16'(rdata), 16'(e));
  endtask

  task automatic close_out();
    if (mismatches == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic clear_ind();
    manual_clear = 1'b1;
    tick();
    manual_clear = 1'b0;
    tick();
  endtask

  task automatic trip_chk(input logic [2:0] t, input logic [2:0] e);
    trip_cmd = t;
    tick();
    chk(16'(shown), 16'(e));
  endtask

  initial begin
    repeat (20000) tick();
    mismatches++;
    close_out();
  end

  initial begin
    repeat (3) tick();
    sys_rst_i = 1'b0;
    chk(16'(ret), 16'h001F);
    rdc(4'h0, 10'h000);
    for (int i = 1; i <= 6; i++) begin
      rt[i] = i[0] ? 4'hC : 4'h3;
      rdc(4'(i), {6'h00, rt[i]});
    end
    rdc(4'h7, 10'h03C);
    rdc(4'h8, 10'h01F);
    rdc(4'hB, 10'h000);
    wr(4'h8, 10'h0F5);
    rdc(4'h8, 10'h015);
    chk(16'(ret), 16'h0015);
    wr(4'h7, 10'h3E8);
    rdc(4'h7, 10'h03C);
    // Random routing and stage traffic
    for (int n = 0; n < 20; n++) begin
      seed = xs(seed);
      g = 1 + int'(seed % 6);
      rt[g] = seed[11:8];
      wr(4'(g), {6'h00, rt[g]});
      rdc(4'(g), {6'h00, rt[g]});
      seed = xs(seed);
      start_cmd = seed[2:0];
      trip_cmd = seed[5:3];
      tick();
      chk(16'(cont), 16'(exp_cont(start_cmd, trip_cmd)));
      chk(16'(strip), 16'(trip_cmd));
    end
    start_cmd = 3'h0;
    trip_cmd = 3'h7;
    wr(4'h0, 10'h070);
    bin_cmd = 1'b1;
    repeat (3) tick();
    chk(16'(strip), 16'h0000);
    wr(4'h0, 10'h020);
    chk(16'(strip), 16'h0005);
    chk(16'(cont), 16'(exp_cont(3'h0, 3'h5)));
    bin_cmd = 1'b0;
    trip_cmd = 3'h0;
    repeat (3) tick();
    foreach (ks[j]) begin
      wr(4'h0, 10'((1 << ks[j]) & 255));
      bin_cmd = 1'b1;
      repeat (3) tick();
      chk(16'(ci), 16'(ks[j] <= 2));
      chk(16'(cm), 16'(ks[j] == 2));
      chk(16'(grp), 16'(ks[j] == 3));
      chk(16'(ang), 16'(ks[j] == 7));
      bin_cmd = 1'b0;
      repeat (3) tick();
      chk(16'({ci, grp, ang}), 16'h0000);
    end
    wr(4'hA, 10'h003);
    rdc(4'hA, 10'h003);
    chk(16'({grp, ang}), 16'h0003);
    wr(4'hA, 10'h000);
    chk(16'({grp, ang}), 16'h0000);
    // Latched contact released by the input
    rt[2] = 4'h1;
    wr(4'h2, 10'h001);
    wr(4'h9, 10'h001);
    trip_cmd = 3'h1;
    tick();
    trip_cmd = 3'h0;
    repeat (2) tick();
    chk(16'(po1), 16'h0001);
    wr(4'h0, 10'h002);
    bin_cmd = 1'b1;
    repeat (4) tick();
    chk(16'(po1), 16'h0000);
    bin_cmd = 1'b0;
    repeat (3) tick();
    wr(4'h9, 10'h000);
    wr(4'h0, 10'h000);
    // Indication hold of one minute
    wr(4'h7, 10'h001);
    clear_ind();
    chk(16'(shown), 16'h0000);
    trip_chk(3'h1, 3'h1);
    trip_chk(3'h3, 3'h1);
    trip_cmd = 3'h1;
    repeat (45) tick();
    trip_chk(3'h3, 3'h2);
    // Hold until manual clear
    wr(4'h7, 10'h3E7);
    trip_cmd = 3'h0;
    clear_ind();
    trip_chk(3'h1, 3'h1);
    trip_cmd = 3'h0;
    repeat (45) tick();
    trip_chk(3'h2, 3'h1);
    clear_ind();
    trip_chk(3'h0, 3'h0);
    trip_chk(3'h2, 3'h2);
    // Zero hold always replaceable
    wr(4'h7, 10'h000);
    trip_chk(3'h0, 3'h2);
    trip_chk(3'h1, 3'h1);
    trip_chk(3'h3, 3'h2);
    close_out();
  end
endmodule
`default_nettype wire
